// File: bench/egr_axes_model.sv
module egr_axes_model (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic signed [31:0] speed_i,
   output logic signed [31:0]      leader_vel_o,
   output logic signed [31:0]      leader_pos_delta_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Leader axis takes the requested speed one cycle late
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         leader_vel_o <= 32'sh0000_0000;
      end else begin
         leader_vel_o <= speed_i;
      end
   end

   // Position change per motion cycle equals leader speed
   assign leader_pos_delta_o = leader_vel_o;
endmodule

// File: bench/egr_gear_sva.sv
module egr_gear_sva #(
   parameter int unsigned CYCLE_CLKS = 8
) (
   input wire logic                   clk_i,
   input wire logic                   rst_i,
   input wire logic [7:0]             avs_address,
   input wire logic                   avs_write,
   input wire logic [31:0]            avs_writedata,
   input wire logic                   avs_waitrequest,
   input wire egr_pkg::egr_axis_cmd_t follower_cmd_o,
   input wire logic                   in_gear_o,
   input wire logic                   busy_o
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   logic ctrl_wr;

   // Accepted write to the command register
   assign ctrl_wr = avs_write && !avs_waitrequest && avs_address == egr_pkg::OFS_CTRL;

   a_busy_active: assert property (follower_cmd_o.active == busy_o)
      else $error("active differs from busy");
   a_gear_busy: assert property (in_gear_o |-> busy_o)
      else $error("in gear while idle");
   a_gear_hold: assert property (in_gear_o && !ctrl_wr |=> in_gear_o)
      else $error("in gear dropped without command");
   a_vel_tick: assert property ($changed(follower_cmd_o.vel) && $past(busy_o) && busy_o
      |=> ($stable(follower_cmd_o.vel) || !busy_o)[*7])
      else $error("velocity changed between ticks");
   a_pos_tick: assert property ($changed(follower_cmd_o.pos) && $past(busy_o) && busy_o
      |=> ($stable(follower_cmd_o.pos) || !busy_o)[*7])
      else $error("position changed between ticks");
   a_idle_still: assert property (!busy_o && $past(!busy_o)
      |-> $stable(follower_cmd_o.vel) && $stable(follower_cmd_o.pos))
      else $error("follower moved while idle");
   a_stop_zero: assert property ($fell(busy_o) |-> follower_cmd_o.vel == 32'sh0000_0000)
      else $error("follower not stopped at end");
   a_disengage_exit: assert property (ctrl_wr && avs_writedata[1] && !avs_writedata[0] && in_gear_o
      |=> !in_gear_o)
      else $error("disengage left follower in gear");
endmodule

bind egr_gear egr_gear_sva #(.CYCLE_CLKS(CYCLE_CLKS)) i_sva (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .avs_address(avs_address),
   .avs_write(avs_write),
   .avs_writedata(avs_writedata),
   .avs_waitrequest(avs_waitrequest),
   .follower_cmd_o(follower_cmd_o),
   .in_gear_o(in_gear_o),
   .busy_o(busy_o)
);

// File: bench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic                   clk_i, rst_i, avs_read, avs_write, in_gear_o, busy_o, irq_o;
   logic [7:0]             avs_address;
   logic [31:0]            avs_writedata, avs_readdata, st;
   logic                   avs_waitrequest;
   logic signed [31:0]     leader_vel_i, leader_pos_delta_i, speed;
   egr_pkg::egr_axis_cmd_t follower_cmd_o;
   int                     miscompares, samples_checked;

   egr_gear #(.CYCLE_CLKS(8)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .leader_vel_i(leader_vel_i), .leader_pos_delta_i(leader_pos_delta_i),
      .follower_cmd_o(follower_cmd_o), .in_gear_o(in_gear_o), .busy_o(busy_o), .irq_o(irq_o));

   egr_axes_model i_axes (
      .clk_i(clk_i), .rst_i(rst_i), .speed_i(speed),
      .leader_vel_o(leader_vel_i), .leader_pos_delta_o(leader_pos_delta_i));

   // Clock generation
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask

   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge clk_i);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0000_0000, st);
   endtask

   // Wait: 0 for in gear, 1 for idle, 2 for a velocity change
   task automatic wait_for(input int k);
      logic [31:0] v;
      v = follower_cmd_o.vel;
      for (int n = 0; n <= 400; n++) begin
         if ((k == 0 && in_gear_o === 1'b1) || (k == 1 && busy_o === 1'b0)
             || (k == 2 && follower_cmd_o.vel !== v)) break;
         if (n == 400) chk("wait limit", 32'h0000_0000, 32'h0000_0001);
         @(posedge clk_i);
      end
   endtask

   task automatic t_reset();
      rd(egr_pkg::OFS_RATIO_NUM); chk("num", 32'h0000_0001, st);
      rd(egr_pkg::OFS_RATIO_DEN); chk("den", 32'h0000_0001, st);
      rd(egr_pkg::OFS_OUT_CFG); chk("out cfg", 32'h0000_0001, st);
      rd(egr_pkg::OFS_STATUS); chk("status", 32'h0000_0000, st);
      rd(8'h3c); chk("unmapped", 32'h0000_0000, st);
      $display("test reset done");
   endtask

   task automatic t_errors();
      wr(egr_pkg::OFS_IRQ_EN, 32'h0000_0007);
      wr(egr_pkg::OFS_RATIO_DEN, 32'h0000_0000);
      wr(egr_pkg::OFS_CTRL, 32'h0000_0001);
      rd(egr_pkg::OFS_STATUS); chk("zero den", 32'h0001_0020, st & 32'hffff_0020);
      @(posedge clk_i);
      chk("irq set", 32'h0000_0001, {31'h0, irq_o});
      wr(egr_pkg::OFS_IRQ_EN, 32'h0000_0000);
      @(posedge clk_i);
      chk("irq masked", 32'h0000_0000, {31'h0, irq_o});
      wr(egr_pkg::OFS_IRQ_CLR, 32'h0000_0004);
      wr(egr_pkg::OFS_IRQ_EN, 32'h0000_0007);
      @(posedge clk_i);
      chk("irq cleared", 32'h0000_0000, {31'h0, irq_o});
      wr(egr_pkg::OFS_CTRL, 32'h0000_0002);
      rd(egr_pkg::OFS_STATUS); chk("not geared", 32'h0002_0020, st & 32'hffff_0020);
      wr(egr_pkg::OFS_OUT_CFG, 32'h0000_0101);
      wr(egr_pkg::OFS_CTRL, 32'h0000_0002);
      rd(egr_pkg::OFS_STATUS); chk("bad curve", 32'h0003_0020, st & 32'hffff_0020);
      wr(egr_pkg::OFS_OUT_CFG, 32'h0000_0001);
      wr(egr_pkg::OFS_RATIO_DEN, 32'h0000_0001);
      wr(egr_pkg::OFS_IRQ_CLR, 32'h0000_0007);
      $display("test errors done");
   endtask

   task automatic run_gear(input logic [15:0] num, input logic [15:0] den, input logic [31:0] tgt,
                           input logic [31:0] step);
      logic [31:0] p0;
      wr(egr_pkg::OFS_RATIO_NUM, {16'h0000, num});
      wr(egr_pkg::OFS_RATIO_DEN, {16'h0000, den});
      wr(egr_pkg::OFS_ACCEL, 32'h0000_0003);
      wr(egr_pkg::OFS_DECEL, 32'h0000_0003);
      wr(egr_pkg::OFS_OUT_CFG, 32'h0000_0001);
      wr(egr_pkg::OFS_CTRL, 32'h0000_0001);
      wait_for(2);
      chk("catch step", step, follower_cmd_o.vel);
      chk("catching", 32'h0000_0000, {31'h0, in_gear_o});
      wait_for(0);
      rd(egr_pkg::OFS_FOL_VEL); chk("geared vel", tgt, st);
      rd(egr_pkg::OFS_FOL_POS);
      p0 = st;
      repeat (5) @(posedge clk_i);
      rd(egr_pkg::OFS_FOL_POS); chk("pos step", tgt, st - p0);
      wr(egr_pkg::OFS_CTRL, 32'h0000_0002);
      wait_for(1);
      rd(egr_pkg::OFS_STATUS); chk("abort flags", 32'h0000_0018, st & 32'h0000_0018);
      chk("stopped", 32'h0000_0000, follower_cmd_o.vel);
      $display("test gear %h/%h done", num, den);
   endtask

   task automatic t_decel_stop();
      wr(egr_pkg::OFS_RATIO_NUM, 32'h0000_0001);
      wr(egr_pkg::OFS_RATIO_DEN, 32'h0000_0001);
      wr(egr_pkg::OFS_CTRL, 32'h0000_0001);
      wait_for(0);
      speed <= 32'sh0000_001a;
      repeat (12) @(posedge clk_i);
      rd(egr_pkg::OFS_FOL_VEL); chk("direct follow", 32'h0000_001a, st);
      wr(egr_pkg::OFS_OUT_CFG, 32'h0000_0000);
      wr(egr_pkg::OFS_OUT_DECEL, 32'h0000_0005);
      wr(egr_pkg::OFS_CTRL, 32'h0000_0002);
      wait_for(2);
      chk("decel step", 32'h0000_0015, follower_cmd_o.vel);
      chk("stopping busy", 32'h0000_0001, {31'h0, busy_o});
      wait_for(1);
      chk("stopped", 32'h0000_0000, follower_cmd_o.vel);
      rd(egr_pkg::OFS_STATUS); chk("done", 32'h0000_0010, st & 32'h0000_0010);
      chk("leader kept", 32'h0000_001a, leader_vel_i);
      rd(egr_pkg::OFS_IRQ_STAT); chk("irq stat", 32'h0000_0003, st);
      $display("test decel stop done");
   endtask

   // Watchdog against a hang
   initial begin
      #100_000;
      miscompares++;
      final_report();
   end

   // Main sequence
   initial begin
      miscompares = 0;
      samples_checked = 0;
      rst_i = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h0000_0000;
      speed = 32'sh0000_0014;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_errors();
      run_gear(16'h0001, 16'h0001, 32'h0000_0014, 32'h0000_0003);
      run_gear(16'hffff, 16'h0001, 32'hffff_ffec, 32'hffff_fffd);
      run_gear(16'h0003, 16'h0002, 32'h0000_001e, 32'h0000_0003);
      t_decel_stop();
      final_report();
   end
endmodule

// File: include/egr_pkg.sv
package egr_pkg;

   // Motion cycle timing
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned CYCLE_US       = 1000;
   localparam int unsigned CYCLE_CLKS     = CYCLE_US * (CLK_HZ / 1_000_000);

   // Data widths
   localparam int unsigned VEL_W          = 32;
   localparam int unsigned RATIO_W        = 16;

   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_RATIO_NUM  = 8'h04;
   localparam logic [7:0]  OFS_RATIO_DEN  = 8'h08;
   localparam logic [7:0]  OFS_ACCEL      = 8'h0c;
   localparam logic [7:0]  OFS_DECEL      = 8'h10;
   localparam logic [7:0]  OFS_OUT_DECEL  = 8'h14;
   localparam logic [7:0]  OFS_OUT_CFG    = 8'h18;
   localparam logic [7:0]  OFS_STATUS     = 8'h1c;
   localparam logic [7:0]  OFS_FOL_VEL    = 8'h20;
   localparam logic [7:0]  OFS_IRQ_STAT   = 8'h24;
   localparam logic [7:0]  OFS_IRQ_CLR    = 8'h28;
   localparam logic [7:0]  OFS_IRQ_EN     = 8'h2c;
   localparam logic [7:0]  OFS_FOL_POS    = 8'h30;

   // Control register bits (write-one pulses)
   localparam int unsigned CTRL_ENGAGE_BIT    = 0;
   localparam int unsigned CTRL_DISENGAGE_BIT = 1;

   // Disengage configuration fields
   localparam int unsigned OUT_CFG_STOP_BIT   = 0;
   localparam int unsigned OUT_CFG_CURVE_LSB  = 8;
   localparam logic [7:0]  CURVE_TRAPEZOID    = 8'h00;

   // Stop select codes
   localparam logic        STOP_DECEL         = 1'b0;
   localparam logic        STOP_IMMEDIATE     = 1'b1;

   // Status register bit positions
   localparam int unsigned ST_BUSY_BIT    = 0;
   localparam int unsigned ST_ACTIVE_BIT  = 1;
   localparam int unsigned ST_IN_GEAR_BIT = 2;
   localparam int unsigned ST_ABORTED_BIT = 3;
   localparam int unsigned ST_DONE_BIT    = 4;
   localparam int unsigned ST_ERROR_BIT   = 5;
   localparam int unsigned ST_STOPPING_BIT = 6;
   localparam int unsigned ST_CODE_LSB    = 16;

   // Interrupt bits
   localparam int unsigned IRQ_IN_GEAR_BIT = 0;
   localparam int unsigned IRQ_DONE_BIT    = 1;
   localparam int unsigned IRQ_ERROR_BIT   = 2;
   localparam int unsigned IRQ_W           = 3;

   // Reset values
   localparam logic [RATIO_W-1:0] RATIO_NUM_RST = 16'h0001;
   localparam logic [RATIO_W-1:0] RATIO_DEN_RST = 16'h0001;
   localparam logic [VEL_W-1:0]   ACCEL_RST     = 32'h0000_0000;
   localparam logic [VEL_W-1:0]   DECEL_RST     = 32'h0000_0000;
   localparam logic               STOP_SEL_RST  = STOP_IMMEDIATE;

   // Fault codes
   localparam logic [15:0] FAULT_NONE      = 16'h0000;
   localparam logic [15:0] FAULT_ZERO_DEN  = 16'h0001;
   localparam logic [15:0] FAULT_NOT_GEAR  = 16'h0002;
   localparam logic [15:0] FAULT_BAD_CURVE = 16'h0003;
   localparam logic [15:0] FAULT_BAD_STOP  = 16'h0004;

   typedef enum logic [1:0] {
      EGR_IDLE,
      EGR_CATCH,
      EGR_IN_GEAR,
      EGR_STOP
   } egr_state_t;

   // Command sent to the follower axis each motion cycle
   typedef struct packed {
      logic signed [VEL_W-1:0] vel;
      logic signed [VEL_W-1:0] pos;
      logic                    active;
   } egr_axis_cmd_t;

endpackage

// File: verilog/egr_gear.sv
// How it works
// - follower ramps toward leader velocity times ratio
// - catching before target, in gear after it
// - positive ratio moves follower with leader
// - negative ratio moves follower against leader
// - raise in-gear once follower velocity equals target
// - in gear, follow leader position changes directly
// - disengage aborts gearing, stops follower at once or with deceleration per stop select
// - disengage touches only the follower, never leader
// - curve code zero means trapezoid, only one supported
module egr_gear #(
   parameter int unsigned CYCLE_CLKS = egr_pkg::CYCLE_CLKS,
   parameter int unsigned VEL_W      = egr_pkg::VEL_W,
   parameter int unsigned RATIO_W    = egr_pkg::RATIO_W
) (
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   // Avalon-MM slave
   input  wire logic [7:0]                   avs_address,
   input  wire logic                         avs_read,
   input  wire logic                         avs_write,
   input  wire logic [31:0]                  avs_writedata,
   input  wire logic [3:0]                   avs_byteenable,
   output logic      [31:0]                  avs_readdata,
   output logic                              avs_waitrequest,
   // Leader axis, sampled on each motion cycle
   input  wire logic signed [VEL_W-1:0]      leader_vel_i,
   input  wire logic signed [VEL_W-1:0]      leader_pos_delta_i,
   // Follower axis command
   output egr_pkg::egr_axis_cmd_t            follower_cmd_o,
   output logic                              in_gear_o,
   output logic                              busy_o,
   output logic                              irq_o
);

   // Motion cycle divider
   logic [$clog2(CYCLE_CLKS+1)-1:0] div_q;
   logic                            tick;

   always_ff @(posedge clk_i) begin
      if (rst_i || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end
   assign tick = (div_q == ($clog2(CYCLE_CLKS+1))'(CYCLE_CLKS - 1));

   // Bus handshake: one wait cycle, answer on the second edge
   logic ack_q;
   logic wr_en;
   logic [31:0] wmask;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read || avs_write) && !ack_q;
      end
   end
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign wr_en = avs_write && ack_q;
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   // Configuration registers
   logic signed [RATIO_W-1:0] num_q;
   logic        [RATIO_W-1:0] den_q;
   logic        [VEL_W-1:0]   acc_q;
   logic        [VEL_W-1:0]   dec_q;
   logic        [VEL_W-1:0]   out_dec_q;
   logic                      stop_sel_q;
   logic        [7:0]         curve_q;
   logic        [31:0]        cfg_wd;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         num_q      <= egr_pkg::RATIO_NUM_RST;
         den_q      <= egr_pkg::RATIO_DEN_RST;
         acc_q      <= egr_pkg::ACCEL_RST;
         dec_q      <= egr_pkg::DECEL_RST;
         out_dec_q  <= egr_pkg::DECEL_RST;
         stop_sel_q <= egr_pkg::STOP_SEL_RST;
         curve_q    <= egr_pkg::CURVE_TRAPEZOID;
      end else if (wr_en) begin
         if (avs_address == egr_pkg::OFS_RATIO_NUM) begin
            num_q <= cfg_wd[RATIO_W-1:0];
         end else if (avs_address == egr_pkg::OFS_RATIO_DEN) begin
            den_q <= cfg_wd[RATIO_W-1:0];
         end else if (avs_address == egr_pkg::OFS_ACCEL) begin
            acc_q <= cfg_wd;
         end else if (avs_address == egr_pkg::OFS_DECEL) begin
            dec_q <= cfg_wd;
         end else if (avs_address == egr_pkg::OFS_OUT_DECEL) begin
            out_dec_q <= cfg_wd;
         end else if (avs_address == egr_pkg::OFS_OUT_CFG) begin
            stop_sel_q <= cfg_wd[egr_pkg::OUT_CFG_STOP_BIT];
            curve_q    <= cfg_wd[egr_pkg::OUT_CFG_CURVE_LSB +: 8];
         end
      end
   end

   // Merge of write data into current register value by byte lane
   logic [31:0] cur_word;

   always_comb begin
      if (avs_address == egr_pkg::OFS_RATIO_NUM) begin
         cur_word = {{(32-RATIO_W){1'b0}}, num_q};
      end else if (avs_address == egr_pkg::OFS_RATIO_DEN) begin
         cur_word = {{(32-RATIO_W){1'b0}}, den_q};
      end else if (avs_address == egr_pkg::OFS_ACCEL) begin
         cur_word = acc_q;
      end else if (avs_address == egr_pkg::OFS_DECEL) begin
         cur_word = dec_q;
      end else if (avs_address == egr_pkg::OFS_OUT_DECEL) begin
         cur_word = out_dec_q;
      end else begin
         cur_word = {16'h0000, curve_q, 7'h00, stop_sel_q};
      end
   end
   assign cfg_wd = (avs_writedata & wmask) | (cur_word & ~wmask);

   // Command pulses from the control register
   logic engage_cmd;
   logic disengage_cmd;
   assign engage_cmd    = wr_en && (avs_address == egr_pkg::OFS_CTRL)
                          && avs_byteenable[0] && avs_writedata[egr_pkg::CTRL_ENGAGE_BIT];
   assign disengage_cmd = wr_en && (avs_address == egr_pkg::OFS_CTRL)
                          && avs_byteenable[0] && avs_writedata[egr_pkg::CTRL_DISENGAGE_BIT];

   // Target velocity: leader times signed ratio, sign carried by numerator
   logic signed [VEL_W+RATIO_W-1:0] prod;
   logic signed [VEL_W+RATIO_W-1:0] quot;
   logic signed [VEL_W-1:0]         target;

   always_comb begin
      prod = leader_vel_i * num_q;
      if (den_q == '0) begin
         quot = '0;
      end else begin
         quot = prod / $signed({1'b0, den_q});
      end
      target = quot[VEL_W-1:0];
   end

   // Direct position follow once in gear
   logic signed [VEL_W+RATIO_W-1:0] pprod;
   logic signed [VEL_W-1:0]         pos_step;

   always_comb begin
      pprod = leader_pos_delta_i * num_q;
      if (den_q == '0) begin
         pos_step = '0;
      end else begin
         pos_step = VEL_W'(pprod / $signed({1'b0, den_q}));
      end
   end

   // State machine and follower velocity
   egr_pkg::egr_state_t     state_q;
   logic signed [VEL_W-1:0] vel_q;
   logic signed [VEL_W-1:0] pos_q;
   logic signed [VEL_W-1:0] ramp_tgt;
   logic        [VEL_W-1:0] ramp_acc;
   logic        [VEL_W-1:0] ramp_dec;
   logic signed [VEL_W-1:0] ramp_nxt;
   logic                    ramp_hit;

   always_comb begin
      if (state_q == egr_pkg::EGR_STOP) begin
         ramp_tgt = '0;
         ramp_acc = out_dec_q;
         ramp_dec = out_dec_q;
      end else begin
         ramp_tgt = target;
         ramp_acc = acc_q;
         ramp_dec = dec_q;
      end
   end

   egr_ramp #(
      .W         (VEL_W)
   ) u_ramp (
      .cur_i     (vel_q),
      .tgt_i     (ramp_tgt),
      .accel_i   (ramp_acc),
      .decel_i   (ramp_dec),
      .nxt_o     (ramp_nxt),
      .reached_o (ramp_hit)
   );

   // Event pulses for flags and interrupts
   logic ev_in_gear;
   logic ev_done;
   logic ev_error;
   logic ev_abort;
   logic [15:0] ev_code;
   logic bad_out;

   assign bad_out = (curve_q != egr_pkg::CURVE_TRAPEZOID);

   always_comb begin
      ev_error = 1'b0;
      ev_code  = egr_pkg::FAULT_NONE;
      if (engage_cmd && (den_q == '0)) begin
         ev_error = 1'b1;
         ev_code  = egr_pkg::FAULT_ZERO_DEN;
      end else if (disengage_cmd && bad_out) begin
         ev_error = 1'b1;
         ev_code  = egr_pkg::FAULT_BAD_CURVE;
      end else if (disengage_cmd && (state_q != egr_pkg::EGR_CATCH)
                   && (state_q != egr_pkg::EGR_IN_GEAR)) begin
         ev_error = 1'b1;
         ev_code  = egr_pkg::FAULT_NOT_GEAR;
      end
   end

   assign ev_abort   = disengage_cmd && !ev_error && !engage_cmd;
   assign ev_in_gear = tick && (state_q == egr_pkg::EGR_CATCH) && ramp_hit && !ev_abort;
   assign ev_done    = tick && (state_q == egr_pkg::EGR_STOP) && ramp_hit;

   // Gearing sequence; leader inputs are only read, never driven
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= egr_pkg::EGR_IDLE;
         vel_q   <= '0;
         pos_q   <= '0;
      end else begin
         case (state_q)
            egr_pkg::EGR_IDLE: begin
               if (engage_cmd && !ev_error) begin
                  state_q <= egr_pkg::EGR_CATCH;
               end
            end
            egr_pkg::EGR_CATCH: begin
               if (ev_abort) begin
                  state_q <= (stop_sel_q == egr_pkg::STOP_IMMEDIATE) ? egr_pkg::EGR_IDLE
                                                                       : egr_pkg::EGR_STOP;
                  if (stop_sel_q == egr_pkg::STOP_IMMEDIATE) begin
                     vel_q <= '0;
                  end
               end else if (tick) begin
                  vel_q <= ramp_nxt;
                  pos_q <= pos_q + ramp_nxt;
                  if (ramp_hit) begin
                     state_q <= egr_pkg::EGR_IN_GEAR;
                  end
               end
            end
            egr_pkg::EGR_IN_GEAR: begin
               if (ev_abort) begin
                  state_q <= (stop_sel_q == egr_pkg::STOP_IMMEDIATE) ? egr_pkg::EGR_IDLE
                                                                       : egr_pkg::EGR_STOP;
                  if (stop_sel_q == egr_pkg::STOP_IMMEDIATE) begin
                     vel_q <= '0;
                  end
               end else if (tick) begin
                  vel_q <= target;
                  pos_q <= pos_q + pos_step;
               end
            end
            egr_pkg::EGR_STOP: begin
               if (tick) begin
                  vel_q <= ramp_nxt;
                  pos_q <= pos_q + ramp_nxt;
                  if (ramp_hit) begin
                     state_q <= egr_pkg::EGR_IDLE;
                  end
               end
            end
            default: begin
               state_q <= egr_pkg::EGR_IDLE;
            end
         endcase
      end
   end

   // Command outcome flags; new engage clears the last outcome
   logic        aborted_q;
   logic        done_q;
   logic        error_q;
   logic [15:0] code_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aborted_q <= 1'b0;
         done_q    <= 1'b0;
         error_q   <= 1'b0;
         code_q    <= egr_pkg::FAULT_NONE;
      end else begin
         if (ev_error) begin
            error_q <= 1'b1;
            code_q  <= ev_code;
         end else if (engage_cmd || disengage_cmd) begin
            error_q <= 1'b0;
            code_q  <= egr_pkg::FAULT_NONE;
         end
         if (ev_abort) begin
            aborted_q <= 1'b1;
         end else if (engage_cmd) begin
            aborted_q <= 1'b0;
         end
         if (ev_done || (ev_abort && stop_sel_q == egr_pkg::STOP_IMMEDIATE)) begin
            done_q <= 1'b1;
         end else if (engage_cmd || disengage_cmd) begin
            done_q <= 1'b0;
         end
      end
   end

   // Sticky interrupt status, set wins over clear
   logic [egr_pkg::IRQ_W-1:0] irq_stat_q;
   logic [egr_pkg::IRQ_W-1:0] irq_en_q;
   logic [egr_pkg::IRQ_W-1:0] irq_set;
   logic [egr_pkg::IRQ_W-1:0] irq_clr;

   always_comb begin
      irq_set = '0;
      irq_set[egr_pkg::IRQ_IN_GEAR_BIT] = ev_in_gear;
      irq_set[egr_pkg::IRQ_DONE_BIT]    = ev_done || (ev_abort && stop_sel_q == egr_pkg::STOP_IMMEDIATE);
      irq_set[egr_pkg::IRQ_ERROR_BIT]   = ev_error;
      irq_clr = '0;
      if (wr_en && (avs_address == egr_pkg::OFS_IRQ_CLR) && avs_byteenable[0]) begin
         irq_clr = avs_writedata[egr_pkg::IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= '0;
         irq_en_q   <= '0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
         if (wr_en && (avs_address == egr_pkg::OFS_IRQ_EN) && avs_byteenable[0]) begin
            irq_en_q <= avs_writedata[egr_pkg::IRQ_W-1:0];
         end
      end
   end
   assign irq_o = |(irq_stat_q & irq_en_q);

   // Status word
   logic [31:0] status;

   always_comb begin
      status = '0;
      status[egr_pkg::ST_BUSY_BIT]     = busy_o;
      status[egr_pkg::ST_ACTIVE_BIT]   = (state_q == egr_pkg::EGR_CATCH) || in_gear_o;
      status[egr_pkg::ST_IN_GEAR_BIT]  = in_gear_o;
      status[egr_pkg::ST_ABORTED_BIT]  = aborted_q;
      status[egr_pkg::ST_DONE_BIT]     = done_q;
      status[egr_pkg::ST_ERROR_BIT]    = error_q;
      status[egr_pkg::ST_STOPPING_BIT] = (state_q == egr_pkg::EGR_STOP);
      status[egr_pkg::ST_CODE_LSB +: 16] = code_q;
   end

   // Registered read data; unmapped and write-only offsets read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         avs_readdata <= '0;
      end else if (avs_read && !ack_q) begin
         if (avs_address == egr_pkg::OFS_STATUS) begin
            avs_readdata <= status;
         end else if (avs_address == egr_pkg::OFS_FOL_VEL) begin
            avs_readdata <= vel_q;
         end else if (avs_address == egr_pkg::OFS_FOL_POS) begin
            avs_readdata <= pos_q;
         end else if (avs_address == egr_pkg::OFS_IRQ_STAT) begin
            avs_readdata <= {{(32-egr_pkg::IRQ_W){1'b0}}, irq_stat_q};
         end else if (avs_address == egr_pkg::OFS_IRQ_EN) begin
            avs_readdata <= {{(32-egr_pkg::IRQ_W){1'b0}}, irq_en_q};
         end else if ((avs_address == egr_pkg::OFS_RATIO_NUM) || (avs_address == egr_pkg::OFS_RATIO_DEN)
                      || (avs_address == egr_pkg::OFS_ACCEL) || (avs_address == egr_pkg::OFS_DECEL)
                      || (avs_address == egr_pkg::OFS_OUT_DECEL) || (avs_address == egr_pkg::OFS_OUT_CFG)) begin
            avs_readdata <= cur_word;
         end else begin
            avs_readdata <= '0;
         end
      end
   end

   // Outputs
   assign in_gear_o             = (state_q == egr_pkg::EGR_IN_GEAR);
   assign busy_o                = (state_q != egr_pkg::EGR_IDLE);
   assign follower_cmd_o.vel    = vel_q;
   assign follower_cmd_o.pos    = pos_q;
   assign follower_cmd_o.active = busy_o;

endmodule

// File: verilog/egr_ramp.sv
// One motion-cycle velocity step toward a target, limited by accel/decel
module egr_ramp #(
   parameter int unsigned W = 32
) (
   input  wire logic signed [W-1:0] cur_i,
   input  wire logic signed [W-1:0] tgt_i,
   input  wire logic        [W-1:0] accel_i,
   input  wire logic        [W-1:0] decel_i,
   output logic signed      [W-1:0] nxt_o,
   output logic                     reached_o
);

   logic signed [W:0] diff;
   logic        [W:0] mag;
   logic        [W-1:0] step;
   logic              speeding_up;

   // Magnitude growing uses accel, shrinking uses decel; zero rate jumps
   always_comb begin
      diff        = {tgt_i[W-1], tgt_i} - {cur_i[W-1], cur_i};
      mag         = diff[W] ? (~diff + 1'b1) : diff;
      speeding_up = (diff[W] == cur_i[W-1]) || (cur_i == '0);
      step        = speeding_up ? accel_i : decel_i;
      if ((step == '0) || (mag <= {1'b0, step})) begin
         nxt_o = tgt_i;
      end else if (diff[W]) begin
         nxt_o = cur_i - $signed(step);
      end else begin
         nxt_o = cur_i + $signed(step);
      end
      reached_o = (nxt_o == tgt_i);
   end

endmodule
